// >>> include/dcsw_pkg.sv
// constants, field positions and state codes of the drive command and
// status word bank; shared by the core, the edge detector and the bench
package dcsw_pkg;
  localparam int DW = 16;
  localparam int AW = 8;
  // register offsets (byte addresses)
  localparam logic [AW-1:0] OFF_CMD = 8'h00;
  localparam logic [AW-1:0] OFF_STAT = 8'h04;
  localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [AW-1:0] OFF_IRQ_MASK = 8'h0c;
  // command word fields
  localparam int CB_RAMP = 0;
  localparam int CB_FREE = 1;
  localparam int CB_FAST = 2;
  localparam int CB_START = 3;
  localparam int CB_CLEAR = 7;
  localparam int CB_VALID = 10;
  localparam int CB_LIFE = 11;
  localparam int CB_VIN_LO = 12;
  localparam logic [DW-1:0] CMD_USED_MASK = 16'hfc8f;
  localparam logic [DW-1:0] CMD_RESET = 16'h0000;
  // status word fields
  localparam int SB_READY = 0;
  localparam int SB_POWER = 1;
  localparam int SB_RUN = 2;
  localparam int SB_FAULT = 3;
  localparam int SB_FAST = 5;
  localparam int SB_WARN = 7;
  localparam int SB_FBCTL = 9;
  localparam int SB_PERMIT = 11;
  localparam int SB_LIFE = 15;
  localparam logic [DW-1:0] STAT_RSV_MASK = 16'h7550;
  localparam logic [DW-1:0] STAT_RESET = 16'h0000;
  // edge detector lanes
  localparam int EDGE_W = 5;
  localparam int EG_START = 0;
  localparam int EG_CLEAR = 1;
  localparam int EG_FAULT = 2;
  localparam int EG_WARN = 3;
  localparam int EG_FAST = 4;
  // interrupt status / mask layout
  localparam int IRQ_W = 5;
  localparam int IB_FAULT = 0;
  localparam int IB_WARN = 1;
  localparam int IB_FAST = 2;
  localparam int IB_START = 3;
  localparam int IB_LIFE = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HALT = 2'b11,
    ST_INHIB = 2'b10
  } dcsw_state_t;
endpackage : dcsw_pkg

// >>> hdl/dcsw_sync.sv
// two-stage synchroniser for one asynchronous level
// assumes the level is slow against sys_clk
`timescale 1ns/1ps
module dcsw_sync (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic async_in,
  output logic sync_out
);
  logic meta;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : dcsw_sync

// >>> hdl/dcsw_rise.sv
// rising edge detector for a small vector of same-clock levels
// assumes its inputs are already in the sys_clk domain
`timescale 1ns/1ps
module dcsw_rise
  import dcsw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [EDGE_W-1:0] level,
  output logic [EDGE_W-1:0] rise
);
  logic [EDGE_W-1:0] prev;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prev <= '0;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
endmodule : dcsw_rise

// >>> hdl/dcsw_core.sv
// drive command word decode and drive status word composition
// assumes drive conditions arrive on sys_clk, run permit from a pin,
// and software on a simple strobe port with one-cycle read latency
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps

// Functional notes
// - data valid low holds last processed word
// - commands act only under fieldbus control; the code gates only bits 0..3 and 7 by it
// - received sign-of-life echoed into status 15
// - bits 12..15 are four virtual inputs
// - ready-to-start cleared by fault or halts
// - status 1 shows power stage ready
// - status 2 shows drive running
// - status 3 fault; fault inhibits switching on
// - status 5 fast halt; restart needs start
// - status 7 shows any active warning
// - status 9 shows fieldbus control active
// - status 11 follows run permit input
// - start on rising bit 3, stop when low
// - rising bit 7 clears events, even with a fault; leaving fault inhibit needs bit 0 low
// - bit 1 low makes drive coast
// - bit 2 low requests fast halt
module dcsw_core
  import dcsw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DW-1:0] rdata,
  input wire logic fb_ctrl,
  input wire logic fault_active,
  input wire logic warning_active,
  input wire logic power_ready,
  input wire logic drive_running,
  input wire logic fast_halt_other,
  input wire logic run_permit_pin,
  output logic run_cmd,
  output logic ramp_halt_cmd,
  output logic freewheel_cmd,
  output logic fast_halt_cmd,
  output logic event_clear,
  output logic cmd_bit12_source,
  output logic cmd_bit13_source,
  output logic cmd_bit14_source,
  output logic cmd_bit15_source,
  output logic irq
);
  logic [DW-1:0] cmd_rx;
  logic [DW-1:0] cmd_act;
  logic [DW-1:0] status_word;
  logic [DW-1:0] next_status;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_evt;
  logic [EDGE_W-1:0] lvl;
  logic [EDGE_W-1:0] rise;
  logic life_prev;
  logic permit;
  dcsw_state_t state;
  dcsw_state_t next_state;

  wire sel_cmd = (addr == OFF_CMD);
  wire sel_stat = (addr == OFF_STAT);
  wire sel_ist = (addr == OFF_IRQ_STAT);
  wire sel_imask = (addr == OFF_IRQ_MASK);
  wire cmd_wr = wr && sel_cmd;

  dcsw_sync u_permit (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in(run_permit_pin),
    .sync_out(permit)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cmd_rx <= CMD_RESET;
      cmd_act <= CMD_RESET;
    end else if (cmd_wr) begin
      cmd_rx <= wdata;
      if (wdata[CB_VALID]) begin
        cmd_act <= wdata & CMD_USED_MASK;
      end
    end
  end

  // gate by control place
  // halt bits are active low, so a foreign control place sees them idle
  wire fb_ramp = fb_ctrl && !cmd_act[CB_RAMP];
  wire fb_free = fb_ctrl && !cmd_act[CB_FREE];
  wire fb_fast = fb_ctrl && !cmd_act[CB_FAST];
  wire fb_start = fb_ctrl && cmd_act[CB_START];
  wire fb_clear = fb_ctrl && cmd_act[CB_CLEAR];
  // start low stops, but only under fieldbus control
  wire fb_stop = fb_ctrl && !cmd_act[CB_START];
  wire fast_any = fb_fast || fast_halt_other;

  assign lvl[EG_START] = fb_start;
  assign lvl[EG_CLEAR] = fb_clear;
  assign lvl[EG_FAULT] = fault_active;
  assign lvl[EG_WARN] = warning_active;
  assign lvl[EG_FAST] = fast_any;

  dcsw_rise u_rise (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .level(lvl),
    .rise(rise)
  );

  wire any_halt = fb_ramp || fb_free || fast_any;
  wire start_ok = rise[EG_START] && !any_halt && !fault_active;
  // fault acknowledged by ramp bit low
  wire inhib_ack = !fault_active && fb_ramp;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fast_any) begin
          next_state = ST_HALT;
        end else if (fb_stop || fb_ramp || fb_free) begin
          next_state = ST_IDLE;
        end
      end
      ST_HALT: begin
        if (!fast_any) begin
          next_state = ST_IDLE;
        end
      end
      ST_INHIB: begin
        if (inhib_ack) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (fault_active) begin
      next_state = ST_INHIB;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign run_cmd = (state == ST_RUN);
  assign ramp_halt_cmd = fb_ramp;
  assign freewheel_cmd = fb_free;
  assign fast_halt_cmd = fast_any;
  assign event_clear = rise[EG_CLEAR];

  // virtual inputs
  // these feed function selection, so they follow data valid but
  // not the control place
  assign cmd_bit12_source = cmd_act[CB_VIN_LO];
  assign cmd_bit13_source = cmd_act[CB_VIN_LO+1];
  assign cmd_bit14_source = cmd_act[CB_VIN_LO+2];
  assign cmd_bit15_source = cmd_act[CB_VIN_LO+3];

  always_comb begin
    next_status = '0;
    next_status[SB_READY] = !fault_active && !any_halt &&
      (state != ST_INHIB);
    next_status[SB_POWER] = power_ready;
    next_status[SB_RUN] = drive_running;
    next_status[SB_FAULT] = fault_active;
    next_status[SB_FAST] = fast_any;
    next_status[SB_WARN] = warning_active;
    next_status[SB_FBCTL] = fb_ctrl;
    next_status[SB_PERMIT] = permit;
    // sign-of-life echo
    // taken from the raw word so the echo works even with data invalid
    next_status[SB_LIFE] = cmd_rx[CB_LIFE];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      status_word <= STAT_RESET;
    end else begin
      status_word <= next_status;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      life_prev <= 1'b0;
    end else begin
      life_prev <= cmd_rx[CB_LIFE];
    end
  end

  assign irq_evt[IB_FAULT] = rise[EG_FAULT];
  assign irq_evt[IB_WARN] = rise[EG_WARN];
  assign irq_evt[IB_FAST] = rise[EG_FAST];
  assign irq_evt[IB_START] = start_ok && (state == ST_IDLE);
  assign irq_evt[IB_LIFE] = life_prev != cmd_rx[CB_LIFE];

  wire [IRQ_W-1:0] w1c = (wr && sel_ist) ? wdata[IRQ_W-1:0] : '0;

  // set wins over a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_stat <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
    end else begin
      irq_stat <= (irq_stat & ~w1c) | irq_evt;
      if (wr && sel_imask) begin
        irq_mask <= wdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

  wire [DW-1:0] rd_mux =
    sel_cmd ? cmd_rx :
    sel_stat ? status_word :
    sel_ist ? {{(DW-IRQ_W){1'b0}}, irq_stat} :
    sel_imask ? {{(DW-IRQ_W){1'b0}}, irq_mask} : '0;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= '0;
    end
  end

  AST_DATA_HOLD:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && !wdata[CB_VALID] |=> $stable(cmd_act))
    else $error("invalid data changed the applied word");

  AST_DATA_TAKE:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr && wdata[CB_VALID] |=>
      cmd_act == ($past(wdata) & CMD_USED_MASK))
    else $error("valid data not applied or reserved bits kept");

  AST_LIFE_ECHO:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmd_wr ##1 1'b1 |=> status_word[SB_LIFE] == $past(wdata[CB_LIFE], 2))
    else $error("sign-of-life echo wrong");

  AST_NO_CTRL:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    !fb_ctrl && !fast_halt_other && state == ST_IDLE |=> state != ST_RUN)
    else $error("start taken without fieldbus control");

  AST_READY_CLR:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    fault_active || fb_ramp || fb_free || fast_any |=>
      !status_word[SB_READY])
    else $error("ready flag set while halted or faulted");

  AST_FAULT_INHIB:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    fault_active |=> state == ST_INHIB && status_word[SB_FAULT])
    else $error("fault did not inhibit switching on");

  AST_FAST_RESTART:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    state == ST_HALT |=> state != ST_RUN)
    else $error("ran again after fast halt without new start");

  AST_FAST_FLAG:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    fast_halt_other |=> status_word[SB_FAST])
    else $error("fast halt from other source not shown");

  AST_PERMIT:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(run_permit_pin) ##1 run_permit_pin[*2] |=>
      status_word[SB_PERMIT])
    else $error("run permit not reflected in time");

  AST_START:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    state == ST_IDLE && start_ok && !fault_active |=> run_cmd)
    else $error("start edge did not start the drive");

  AST_STOP:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    state == ST_RUN && fb_stop && !fault_active |=> !run_cmd)
    else $error("start low did not stop the drive");

  AST_RESERVED:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    (status_word & STAT_RSV_MASK) == '0)
    else $error("reserved status bit set");

  AST_STAT_READ:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd && sel_stat |=> rdata == $past(status_word))
    else $error("status read not coherent");

  AST_RD_IDLE:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    !rd |=> rdata == '0)
    else $error("read data stood outside the read cycle");
endmodule : dcsw_core

// >>> tb/dcsw_ctrl_model.sv
// fieldbus controller model: master of the register port
// assumes one sys_clk domain and a slave that never stalls
`timescale 1ns/1ps
module dcsw_ctrl_model
  import dcsw_pkg::*;
(
  input wire logic sys_clk,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [DW-1:0] rdata
);
  logic life = 1'b0;
  logic [DW-1:0] last_sent = 16'h0000;
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  task bus_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    // released data lines must not keep looking valid
    wdata <= ~d;
  endtask : bus_wr
  task bus_rd(input logic [AW-1:0] a, output logic [DW-1:0] q);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask : bus_rd
  task send_cmd(input logic [DW-1:0] d);
    life = ~life;
    last_sent = {d[15:12], life, d[10:0]};
    bus_wr(OFF_CMD, last_sent);
  endtask : send_cmd
endmodule : dcsw_ctrl_model

// >>> tb/test_drive_control_status_words.sv
// self-checking bench of the command and status word bank
// assumes the controller model as bus master and bench-driven drive levels
`timescale 1ns/1ps
module test_drive_control_status_words
  import dcsw_pkg::*;
;
  logic sys_clk, rst_b, wr, rd, irq, event_clear;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, app, q;
  logic fb_ctrl, fault_active, warning_active, power_ready;
  logic drive_running, fast_halt_other, run_permit_pin;
  logic run_cmd, ramp_halt_cmd, freewheel_cmd, fast_halt_cmd;
  logic cmd_bit12_source, cmd_bit13_source;
  logic cmd_bit14_source, cmd_bit15_source;
  int miscompares = 0;
  int tests_run = 0;
  int ec_cnt = 0;
  int n;
  dcsw_core dcsw_core_i (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fb_ctrl(fb_ctrl),
    .fault_active(fault_active), .warning_active(warning_active),
    .power_ready(power_ready), .drive_running(drive_running),
    .fast_halt_other(fast_halt_other), .run_permit_pin(run_permit_pin),
    .run_cmd(run_cmd), .ramp_halt_cmd(ramp_halt_cmd),
    .freewheel_cmd(freewheel_cmd), .fast_halt_cmd(fast_halt_cmd),
    .event_clear(event_clear), .cmd_bit12_source(cmd_bit12_source),
    .cmd_bit13_source(cmd_bit13_source),
    .cmd_bit14_source(cmd_bit14_source),
    .cmd_bit15_source(cmd_bit15_source), .irq(irq));
  dcsw_ctrl_model dcsw_ctrl_model_i (.sys_clk(sys_clk), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (event_clear === 1'b1) ec_cnt <= ec_cnt + 1;
  task results;
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task check(input string what, input logic [DW-1:0] seen,
    input logic [DW-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task check1(input string what, input logic seen, input logic exp);
    check(what, {15'h0000, seen}, {15'h0000, exp});
  endtask : check1
  task settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle
  // the applied word only moves when the data-valid bit is set
  task cmd(input logic [DW-1:0] d);
    dcsw_ctrl_model_i.send_cmd(d);
    if (d[CB_VALID]) app = d & CMD_USED_MASK;
    settle();
  endtask : cmd
  task rd_chk(input string what, input logic [AW-1:0] a,
    input logic [DW-1:0] exp, input logic [DW-1:0] m);
    dcsw_ctrl_model_i.bus_rd(a, q);
    check(what, q & m, exp & m);
  endtask : rd_chk
  function automatic logic [DW-1:0] exp_st();
    logic [DW-1:0] s;
    s = 16'h0000;
    s[SB_POWER] = power_ready;
    s[SB_RUN] = drive_running;
    s[SB_FAULT] = fault_active;
    s[SB_FAST] = fast_halt_other | (fb_ctrl & ~app[CB_FAST]);
    s[SB_WARN] = warning_active;
    s[SB_FBCTL] = fb_ctrl;
    s[SB_PERMIT] = run_permit_pin;
    s[SB_LIFE] = dcsw_ctrl_model_i.last_sent[CB_LIFE];
    return s;
  endfunction : exp_st
  task st_chk;
    rd_chk("status", OFF_STAT, exp_st(), 16'hfffe);
  endtask : st_chk
  task vin_chk;
    check("vin", {12'h000, cmd_bit15_source, cmd_bit14_source,
      cmd_bit13_source, cmd_bit12_source}, {12'h000, app[15:12]});
  endtask : vin_chk
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    app = 16'h0000;
    {fb_ctrl, fault_active, warning_active, power_ready} = 4'h0;
    {drive_running, fast_halt_other, run_permit_pin} = 3'h0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    // one drive level at a time, then all low
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      {fb_ctrl, fault_active, warning_active, power_ready, drive_running,
        fast_halt_other, run_permit_pin} <= 7'(8'h01 << i);
      settle();
      st_chk();
    end
    dcsw_ctrl_model_i.bus_wr(OFF_STAT, 16'hffff);
    st_chk();
    rd_chk("unmapped", 8'h10, 16'h0000, 16'hffff);
    @(posedge sys_clk);
    fb_ctrl <= 1'b1;
    power_ready <= 1'b1;
    cmd(16'hf777);
    vin_chk();
    check("halts", {ramp_halt_cmd, freewheel_cmd, fast_halt_cmd}, 0);
    cmd(16'h0300);
    vin_chk();
    st_chk();
    cmd(16'h5400);
    vin_chk();
    check("halts", {ramp_halt_cmd, freewheel_cmd, fast_halt_cmd}, 7);
    st_chk();
    rd_chk("ready", OFF_STAT, 16'h0000, 16'h0001);
    cmd(16'h0407);
    cmd(16'h040f);
    check1("run", run_cmd, 1'b1);
    rd_chk("ready", OFF_STAT, 16'h0001, 16'h0001);
    rd_chk("irq_stat", OFF_IRQ_STAT, 16'h0008, 16'h0008);
    cmd(16'h0407);
    check1("run", run_cmd, 1'b0);
    cmd(16'h040f);
    cmd(16'h040b);
    check1("fast", fast_halt_cmd, 1'b1);
    st_chk();
    cmd(16'h040f);
    check1("run", run_cmd, 1'b0);
    cmd(16'h0407);
    cmd(16'h040f);
    cmd(16'h040d);
    check1("free", freewheel_cmd, 1'b1);
    check1("run", run_cmd, 1'b0);
    cmd(16'h0407);
    cmd(16'h040f);
    @(posedge sys_clk);
    fault_active <= 1'b1;
    settle();
    check1("run", run_cmd, 1'b0);
    rd_chk("ready", OFF_STAT, 16'h0000, 16'h0001);
    rd_chk("irq_stat", OFF_IRQ_STAT, 16'h0001, 16'h0001);
    check1("irq", irq, 1'b0);
    dcsw_ctrl_model_i.bus_wr(OFF_IRQ_MASK, 16'h0001);
    settle();
    check1("irq", irq, 1'b1);
    @(posedge sys_clk);
    fault_active <= 1'b0;
    dcsw_ctrl_model_i.bus_wr(OFF_IRQ_STAT, 16'h001f);
    settle();
    check1("irq", irq, 1'b0);
    rd_chk("irq_mask", OFF_IRQ_MASK, 16'h0001, 16'hffff);
    n = ec_cnt;
    cmd(16'h048f);
    check("clear", 16'(ec_cnt - n), 16'h0001);
    cmd(16'h0407);
    cmd(16'h040f);
    check1("run", run_cmd, 1'b0);
    cmd(16'h0406);
    cmd(16'h0407);
    cmd(16'h040f);
    check1("run", run_cmd, 1'b1);
    @(posedge sys_clk);
    fb_ctrl <= 1'b0;
    settle();
    cmd(16'h0400);
    check1("run", run_cmd, 1'b1);
    check("halts", {ramp_halt_cmd, freewheel_cmd, fast_halt_cmd}, 0);
    @(posedge sys_clk);
    fast_halt_other <= 1'b1;
    settle();
    check1("fast", fast_halt_cmd, 1'b1);
    check1("run", run_cmd, 1'b0);
    st_chk();
    rd_chk("ready", OFF_STAT, 16'h0000, 16'h0001);
    results();
  end
endmodule : test_drive_control_status_words
